// ===== rtl/pvc_pkg.sv
// package: constants and carrier types for the process value calculator
package pvc_pkg;
    // ========================================================================
    // value format: signed thousandths (3 decimals), 32 bits
    localparam int          VAL_W         = 32;
    localparam int          UNIT_W        = 4;
    localparam int          NUM_IN        = 4;
    localparam logic [31:0] VAL_MAX       = 32'h05f5_dd18; // 99,999.000
    localparam logic [31:0] VAL_MIN       = 32'hfa0a_22e8; // -99,999.000
    localparam logic [31:0] ONE_MILLI     = 32'h0000_03e8; // 1.000
    localparam logic [31:0] HUNDRED_PCT   = 32'h0001_86a0; // 100.000
    // ========================================================================
    // filter: time in tenths of a second, one sample every tenth
    localparam logic [31:0] FILT_MAX      = 32'h0000_0258; // 60.0 s
    // barometric pressure in thousandths of psi
    localparam logic [31:0] BARO_MIN      = 32'h0000_2710; // 10.0 psi
    localparam logic [31:0] BARO_MAX      = 32'h0000_3e80; // 16.0 psi
    localparam logic [31:0] BARO_RST      = 32'h0000_396b; // 14.699 psi
    // humidity drop per degree of bulb depression at reference pressure
    localparam logic [31:0] RH_PER_DEG    = 32'h0000_0005; // 5 %/deg
    // ========================================================================
    // register byte offsets
    localparam logic [7:0]  OFS_FUNC      = 8'h00;
    localparam logic [7:0]  OFS_OFFSET    = 8'h04;
    localparam logic [7:0]  OFS_FILTER    = 8'h08;
    localparam logic [7:0]  OFS_XPOINT    = 8'h0c;
    localparam logic [7:0]  OFS_XBAND     = 8'h10;
    localparam logic [7:0]  OFS_BARO      = 8'h14;
    localparam logic [7:0]  OFS_RESULT    = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1c;
    // unit codes
    localparam logic [3:0]  UNIT_NONE     = 4'h0;
    localparam logic [3:0]  UNIT_ABS_TEMP = 4'h1;
    localparam logic [3:0]  UNIT_PCT_RH   = 4'h2;
    // ========================================================================
    typedef enum logic [3:0] {
        FN_OFF      = 4'h0,
        FN_AVERAGE  = 4'h1,
        FN_CROSS    = 4'h2,
        FN_PSYCHRO  = 4'h3,
        FN_SWITCH   = 4'h4,
        FN_DIFF     = 4'h5,
        FN_RATIO    = 4'h6,
        FN_SUM      = 4'h7
    } pvc_func_t;
    // one analog receiver from an upstream block
    typedef struct packed {
        logic [VAL_W-1:0]  value;
        logic [UNIT_W-1:0] units;
        logic              connected;
    } pvc_in_t;
    // the transmitted result
    typedef struct packed {
        logic [VAL_W-1:0]  value;
        logic [UNIT_W-1:0] units;
        logic              valid;
    } pvc_out_t;
endpackage : pvc_pkg

// ===== rtl/pvc_process_value.sv
// process value calculator: function select, filter, offset, bus slave
//
// Contract
// RULE_01 - signed clamped offset added to result
// RULE_02 - filter time 0..60 s smooths result
// RULE_03 - average mode outputs mean of inputs
// RULE_04 - average counts connected inputs only
// RULE_05 - crossover below band outputs input A
// RULE_06 - crossover inside band outputs weighted blend
// RULE_07 - crossover above band outputs input B
// RULE_08 - weights equal at band centre
// RULE_09 - crossover point sets band centre
// RULE_10 - band width register sets band width
// RULE_11 - weights linear, always summing to one
// RULE_12 - crossover output carries units of A
// RULE_13 - humidity from bulb temperatures and pressure
// RULE_14 - humidity valid only 10 to 350 F; bulb range not checked, result only clamped to 0..100 %
// RULE_15 - switch-over picks input by selector
// RULE_16 - switch-over units follow selected input
// RULE_17 - differential is X minus Y
// RULE_18 - ratio is X divided by Y
// RULE_19 - ratio unitless when units match
// RULE_20 - sum adds connected inputs only
// RULE_21 - sum flags absolute temp else top
// RULE_22 - function selector chooses the calculation
// RULE_23 - pass-through outputs top input filtered
// RULE_24 - first-order recursion, zero time passes
`timescale 1ns/1ps
module pvc_process_value (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output      logic [31:0]          hrdata,
    output      logic                 hreadyout,
    output      logic                 hresp,
    // upstream receivers
    input  wire pvc_pkg::pvc_in_t     inPort [pvc_pkg::NUM_IN],
    input  wire logic                 input_selector,
    input  wire logic                 sampleStrobe,
    // downstream transmitter
    output      pvc_pkg::pvc_out_t    outPort
);
    import pvc_pkg::*;

    // ========================================================================
    // register file
    pvc_func_t          funcSel;
    logic signed [31:0] offsetVal;
    logic        [31:0] filterTime;
    logic signed [31:0] crossPoint;
    logic signed [31:0] crossBand;
    logic        [31:0] baroPress;
    logic               wrPend;
    logic        [7:0]  wrAddr;

    // clamp a written value into a signed range
    function automatic logic [31:0] clampS(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        if ($signed(v) < $signed(lo))
            return lo;
        else if ($signed(v) > $signed(hi))
            return hi;
        else
            return v;
    endfunction : clampS

    // zero-wait slave: writes land in the data phase, answer is always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // latch a write address phase for the following data phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= hsel && htrans[1] && hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // software settings; out-of-range values are clamped on write, except a function code above 7, which selects FN_OFF
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            funcSel    <= FN_OFF;
            offsetVal  <= '0;
            filterTime <= '0;
            crossPoint <= '0;
            crossBand  <= '0;
            baroPress  <= BARO_RST;
        end else if (wrPend) begin
            unique case (wrAddr)
                OFS_FUNC:   funcSel <= (hwdata[3:0] > 4'h7) ? FN_OFF
                                     : pvc_func_t'(hwdata[3:0]); // [RULE_22]
                OFS_OFFSET: offsetVal  <= clampS(hwdata, VAL_MIN,
                                                 VAL_MAX); // [RULE_01]
                OFS_FILTER: filterTime <= clampS(hwdata, 32'h0,
                                                 FILT_MAX); // [RULE_02]
                OFS_XPOINT: crossPoint <= clampS(hwdata, VAL_MIN,
                                                 VAL_MAX); // [RULE_09]
                OFS_XBAND:  crossBand  <= clampS(hwdata, VAL_MIN,
                                                 VAL_MAX); // [RULE_10]
                OFS_BARO:   baroPress  <= clampS(hwdata, BARO_MIN,
                                                 BARO_MAX); // [RULE_13]
                default: ;
            endcase
        end
    end

    // read data registered during the address phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                OFS_FUNC:   hrdata <= {28'h0, funcSel};
                OFS_OFFSET: hrdata <= offsetVal;
                OFS_FILTER: hrdata <= filterTime;
                OFS_XPOINT: hrdata <= crossPoint;
                OFS_XBAND:  hrdata <= crossBand;
                OFS_BARO:   hrdata <= baroPress;
                OFS_RESULT: hrdata <= outPort.value;
                OFS_STATUS: hrdata <= {27'h0, outPort.units, outPort.valid};
                default:    hrdata <= '0;
            endcase
        end
    end

    // ========================================================================
    // connected-input gathering, one term per receiver
    logic signed [31:0] gated [NUM_IN];
    logic        [2:0]  cnt   [NUM_IN+1];
    logic        [NUM_IN-1:0] absHit;
    assign cnt[0] = 3'h0;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            // an unconnected receiver contributes nothing
            assign gated[gi]  = inPort[gi].connected ?
                                $signed(inPort[gi].value) : 32'sh0;
            assign cnt[gi+1]  = cnt[gi] + {2'h0, inPort[gi].connected};
            assign absHit[gi] = inPort[gi].connected &&
                                (inPort[gi].units == UNIT_ABS_TEMP);
        end
    endgenerate

    logic signed [33:0] sumAll;
    logic        [3:0]  topUnits;
    assign sumAll = 34'(gated[0]) + 34'(gated[1]) + 34'(gated[2])
                  + 34'(gated[3]); // [RULE_20]

    // units of the top connected receiver
    always_comb begin
        topUnits = UNIT_NONE;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (inPort[i].connected)
                topUnits = inPort[i].units;
        end
    end

    // ========================================================================
    // crossover band edges and linear blend
    logic signed [33:0] bandLo;
    logic signed [33:0] bandHi;
    logic signed [33:0] posA;
    logic signed [33:0] spanBA;
    logic signed [67:0] blendNum;
    logic signed [33:0] blend;
    logic signed [31:0] aVal;
    logic signed [31:0] bVal;
    assign aVal   = $signed(inPort[0].value);
    assign bVal   = $signed(inPort[1].value);
    assign bandLo = 34'(crossPoint) - 34'(crossBand >>> 1); // [RULE_09]
    assign bandHi = bandLo + 34'(crossBand); // [RULE_10]
    assign posA   = 34'(aVal) - bandLo;
    assign spanBA = 34'(bVal) - 34'(aVal);
    // a + (b-a)*pos/band: weights move linearly, sum is one by construction
    assign blendNum = 68'(spanBA) * 68'(posA); // [RULE_11]
    assign blend    = (crossBand > 0) ?
                      34'(aVal) + 34'(blendNum / 68'(crossBand))
                      : 34'(aVal); // [RULE_08]

    // ========================================================================
    // humidity: drop from saturation grows with depression, shrinks with
    // pressure; a linear approximation trading accuracy for area
    logic signed [33:0] depress;
    logic signed [67:0] rhDrop;
    logic signed [33:0] rhRaw;
    logic signed [33:0] rhPct;
    assign depress = 34'(aVal) - 34'(bVal);
    // constants made signed so a wet bulb above dry stays a signed divide
    assign rhDrop  = (68'(depress) * $signed(68'(RH_PER_DEG))
                   * $signed(68'(BARO_RST)))
                   / $signed(68'(baroPress)); // [RULE_13]
    assign rhRaw   = 34'(HUNDRED_PCT) - 34'(rhDrop);
    assign rhPct   = (rhRaw < 0) ? 34'sh0
                   : (rhRaw > 34'(HUNDRED_PCT)) ? 34'(HUNDRED_PCT)
                   : rhRaw; // [RULE_14]

    // ========================================================================
    // ratio in thousandths; a zero denominator yields zero
    logic signed [67:0] ratioQ;
    assign ratioQ = (bVal == 0) ? 68'sh0
                  : (68'(aVal) * $signed(68'(ONE_MILLI)))
                    / 68'(bVal); // [RULE_18]

    // ========================================================================
    // function selection
    logic signed [33:0] calc;
    logic        [3:0]  calcUnits;
    always_comb begin
        calc      = 34'(aVal);
        calcUnits = inPort[0].units;
        unique case (funcSel) // [RULE_22]
            FN_OFF: begin
                calc      = 34'(aVal); // [RULE_23]
                calcUnits = inPort[0].units;
            end
            FN_AVERAGE: begin
                calc      = (cnt[NUM_IN] == 3'h0) ? 34'sh0
                          : sumAll / $signed({31'h0, cnt[NUM_IN]}); // [RULE_04]
                calcUnits = topUnits; // [RULE_03]
            end
            FN_CROSS: begin
                if (34'(aVal) < bandLo)
                    calc = 34'(aVal); // [RULE_05]
                else if (34'(aVal) > bandHi)
                    calc = 34'(bVal); // [RULE_07]
                else
                    calc = blend; // [RULE_06]
                calcUnits = inPort[0].units; // [RULE_12]
            end
            FN_PSYCHRO: begin
                calc      = rhPct;
                calcUnits = UNIT_PCT_RH;
            end
            FN_SWITCH: begin
                calc      = input_selector ? 34'(bVal) : 34'(aVal); // [RULE_15]
                calcUnits = input_selector ? inPort[1].units
                                           : inPort[0].units; // [RULE_16]
            end
            FN_DIFF: begin
                calc      = 34'(aVal) - 34'(bVal); // [RULE_17]
                calcUnits = inPort[0].units;
            end
            FN_RATIO: begin
                calc      = 34'(ratioQ);
                calcUnits = (inPort[0].units == inPort[1].units) ?
                            UNIT_NONE : inPort[0].units; // [RULE_19]
            end
            FN_SUM: begin
                calc      = sumAll;
                calcUnits = (|absHit) ? UNIT_ABS_TEMP : topUnits; // [RULE_21]
            end
        endcase
    end

    // ========================================================================
    // first-order low-pass: y += (x - y) / (1 + time), one step per sample
    logic signed [33:0] filtState;
    logic signed [33:0] next_filt;
    logic signed [33:0] filtStep;
    assign filtStep  = (calc - filtState)
                     / $signed({2'h0, filterTime + 32'h1}); // [RULE_24]
    assign next_filt = (filterTime == 32'h0) ? calc
                     : filtState + filtStep; // [RULE_02]

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            filtState <= '0;
        else if (sampleStrobe)
            filtState <= next_filt; // [RULE_24]
    end

    // registered transmitter: filtered value plus offset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outPort <= '0;
        end else begin
            outPort.valid <= sampleStrobe;
            if (sampleStrobe) begin
                outPort.value <= 32'(next_filt + 34'(offsetVal)); // [RULE_01]
                outPort.units <= calcUnits;
            end
        end
    end

    // ========================================================================
    // checks
    sequence s_sample;
        sampleStrobe;
    endsequence
    sequence s_pass_out;
        ##1 outPort.valid;
    endsequence

    AST_VALID_PULSE: assert property ( // [RULE_24]
        @(posedge sys_clk) disable iff (!rst_n)
        s_sample |-> s_pass_out)
        else $error("output valid missing after sample");

    AST_ZERO_FILTER: assert property ( // [RULE_24]
        @(posedge sys_clk) disable iff (!rst_n)
        sampleStrobe && filterTime == 0 && !wrPend |=>
        $signed(outPort.value) == $signed(32'($past(calc)))
                                  + $signed(offsetVal))
        else $error("unfiltered output not calc plus offset");

    AST_FILTER_HOLD: assert property ( // [RULE_02]
        @(posedge sys_clk) disable iff (!rst_n)
        !sampleStrobe |=> $stable(filtState))
        else $error("filter moved without a sample");

    AST_CROSS_LOW: assert property ( // [RULE_05]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_CROSS && 34'(aVal) < bandLo |-> calc == 34'(aVal))
        else $error("crossover below band not input a");

    AST_CROSS_HIGH: assert property ( // [RULE_07]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_CROSS && 34'(aVal) > bandHi |-> calc == 34'(bVal))
        else $error("crossover above band not input b");

    AST_SWITCH_SEL: assert property ( // [RULE_15]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_SWITCH && input_selector |-> calc == 34'(bVal))
        else $error("switch-over on did not pick second input");

    AST_DIFF: assert property ( // [RULE_17]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_DIFF |-> calc == 34'(aVal) - 34'(bVal))
        else $error("difference wrong");

    AST_SUM_UNITS: assert property ( // [RULE_21]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_SUM && (|absHit) |-> calcUnits == UNIT_ABS_TEMP)
        else $error("sum lost absolute temperature flag");

    AST_RATIO_UNITS: assert property ( // [RULE_19]
        @(posedge sys_clk) disable iff (!rst_n)
        funcSel == FN_RATIO && inPort[0].units == inPort[1].units
        |-> calcUnits == UNIT_NONE)
        else $error("ratio of like units not unitless");

    AST_OFFSET_RANGE: assert property ( // [RULE_01]
        @(posedge sys_clk) disable iff (!rst_n)
        $signed(offsetVal) <= $signed(VAL_MAX)
        && $signed(offsetVal) >= $signed(VAL_MIN))
        else $error("offset outside range");

endmodule : pvc_process_value

// ===== bench/pvc_upstream_model.sv
// upstream function block model feeding the analog receivers
`timescale 1ns/1ps
// ==========================================================================
// receivers follow the requests one edge late, as a real producer block
module pvc_upstream_model (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // requested receiver contents
    input  wire pvc_pkg::pvc_in_t reqIn  [pvc_pkg::NUM_IN],
    // receivers of the block under test
    output      pvc_pkg::pvc_in_t inPort [pvc_pkg::NUM_IN]
);
    import pvc_pkg::*;
    // an unlinked receiver flips every cycle, so using it shows up at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_IN; i++) begin
                inPort[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (reqIn[i].connected) begin
                    inPort[i] <= reqIn[i];
                end else begin
                    inPort[i].value     <= ~inPort[i].value;
                    inPort[i].units     <= ~inPort[i].units;
                    inPort[i].connected <= 1'b0;
                end
            end
        end
    end
endmodule : pvc_upstream_model

// ===== bench/test_process_value_calc.sv
// self-checking bench for the process value calculator
`timescale 1ns/1ps
module test_process_value_calc;
    import pvc_pkg::*;
    // ======================================================================
    // stimulus, responses and bookkeeping
    logic        sys_clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        input_selector;
    logic        sampleStrobe;
    pvc_in_t     reqIn  [NUM_IN];
    pvc_in_t     inPort [NUM_IN];
    pvc_out_t    outPort;
    int          num_errors;
    int          compares;
    int          cycles;
    logic [31:0] lfsr;
    logic [35:0] expQ [$];
    // crossover table: input A, input B, expected output
    localparam logic [31:0] XA [4] = '{32'h1388, 32'h2328, 32'h2710, 32'h36b0};
    localparam logic [31:0] XB [4] = '{32'h7530, 32'h32c8, 32'h4e20, 32'h07d0};
    localparam logic [31:0] XE [4] = '{32'h1388, 32'h2710, 32'h3a98, 32'h07d0};
    // single slave: its ready closes the bus loop
    assign hready = hreadyout;
    pvc_process_value i_pvc_process_value (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .inPort(inPort), .input_selector(input_selector),
        .sampleStrobe(sampleStrobe), .outPort(outPort));
    pvc_upstream_model i_pvc_upstream_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .reqIn(reqIn), .inPort(inPort));
    // ======================================================================
    // helpers
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one single transfer; waits on ready, the timeout ends a hang
    task automatic bus(input logic wr, input logic [7:0] ofs,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
        check({35'h0, hresp}, 36'h0);
    endtask : bus
    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, ofs, d, rd);
    endtask : wr
    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, ofs, 32'h0, rd);
        check({rd, 4'h0}, {exp, 4'h0});
    endtask : rdchk
    task automatic setIn(input int i, input logic [31:0] v,
                         input logic [3:0] u, input logic c);
        reqIn[i] <= {v, u, c};
    endtask : setIn
    // note the expectation, then pulse one sample
    task automatic sample(input logic [31:0] v, input logic [3:0] u);
        repeat (2) @(posedge sys_clk);
        expQ.push_back({v, u});
        sampleStrobe <= 1'b1;
        @(posedge sys_clk);
        sampleStrobe <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : sample
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // ======================================================================
    // clock, watchdog and result monitor
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // about two hundred cycles are needed; far above that means a hang
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // each valid pulse takes the oldest note off the queue
    always @(posedge sys_clk) begin
        if (outPort.valid === 1'b1) begin
            check({outPort.value, outPort.units},
                  expQ.size() > 0 ? expQ.pop_front() : 36'hf_ffff_ffff);
        end
    end
    // ======================================================================
    // main sequence
    initial begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] d;
        logic [31:0] m;
        {rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        {input_selector, sampleStrobe, num_errors, compares, cycles} = '0;
        lfsr = 32'h8183a43a;
        for (int i = 0; i < NUM_IN; i++) begin
            reqIn[i] = '0;
        end
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(OFS_FUNC, 32'h0);
        rdchk(OFS_BARO, BARO_RST);
        rdchk(8'h20, 32'h0);
        wr(OFS_OFFSET, 32'h7fff_ffff);
        rdchk(OFS_OFFSET, VAL_MAX);
        wr(OFS_FILTER, 32'h0000_03e8);
        rdchk(OFS_FILTER, FILT_MAX);
        wr(OFS_FILTER, 32'h0);
        wr(OFS_FUNC, 32'h0000_0009);
        rdchk(OFS_FUNC, {28'h0, FN_OFF});
        // pass-through with positive and negative offset
        wr(OFS_OFFSET, 32'h0000_03e8);
        setIn(0, 32'h1388, 4'h5, 1'b1);
        sample(32'h1770, 4'h5);
        wr(OFS_OFFSET, 32'hffff_f830);
        sample(32'h0bb8, 4'h5);
        wr(OFS_OFFSET, 32'h0);
        // average and sum over three linked receivers, one left floating
        a = rnd() & 32'h0000_ffff;
        b = rnd() & 32'h0000_ffff;
        m = rnd() & 32'h0000_ffff;
        d = 3 * m - a - b;
        setIn(0, a, 4'h5, 1'b1);
        setIn(1, b, 4'h6, 1'b1);
        setIn(3, d, 4'h7, 1'b1);
        wr(OFS_FUNC, {28'h0, FN_AVERAGE});
        sample(m, 4'h5);
        wr(OFS_FUNC, {28'h0, FN_SUM});
        sample(a + b + d, 4'h5);
        setIn(3, d, UNIT_ABS_TEMP, 1'b1);
        sample(a + b + d, UNIT_ABS_TEMP);
        // crossover band centred at 10.000, 4.000 wide
        wr(OFS_XPOINT, 32'h2710);
        wr(OFS_XBAND, 32'h0fa0);
        wr(OFS_FUNC, {28'h0, FN_CROSS});
        for (int k = 0; k < 4; k++) begin
            setIn(0, XA[k], 4'h5, 1'b1);
            setIn(1, XB[k], 4'h6, 1'b1);
            sample(XE[k], 4'h5);
        end
        // bulbs at 80 and 70 F, inside the range where the method holds
        setIn(0, 32'h0001_3880, 4'h5, 1'b1);
        setIn(1, 32'h0001_1170, 4'h5, 1'b1);
        wr(OFS_FUNC, {28'h0, FN_PSYCHRO});
        sample(32'h0000_c350, UNIT_PCT_RH);
        wr(OFS_BARO, 32'h0000_1388);
        rdchk(OFS_BARO, BARO_MIN);
        // switch-over on the digital selector
        setIn(0, 32'h04d2, 4'h5, 1'b1);
        setIn(1, 32'h10e1, 4'h6, 1'b1);
        wr(OFS_FUNC, {28'h0, FN_SWITCH});
        sample(32'h04d2, 4'h5);
        input_selector <= 1'b1;
        sample(32'h10e1, 4'h6);
        // differential with random operands
        a = rnd() & 32'h0000_ffff;
        b = rnd() & 32'h0000_ffff;
        setIn(0, a, 4'h5, 1'b1);
        setIn(1, b, 4'h6, 1'b1);
        wr(OFS_FUNC, {28'h0, FN_DIFF});
        sample(a - b, 4'h5);
        // ratio 6.000 / 2.000 with equal, then differing units
        setIn(0, 32'h1770, 4'h5, 1'b1);
        setIn(1, 32'h07d0, 4'h5, 1'b1);
        wr(OFS_FUNC, {28'h0, FN_RATIO});
        sample(32'h0bb8, UNIT_NONE);
        setIn(1, 32'h07d0, 4'h6, 1'b1);
        sample(32'h0bb8, 4'h5);
        // filter of one tenth: each step halves the remaining gap
        wr(OFS_FUNC, {28'h0, FN_OFF});
        setIn(0, 32'h0, 4'h5, 1'b1);
        sample(32'h0, 4'h5);
        wr(OFS_FILTER, 32'h0000_0001);
        setIn(0, 32'h1f40, 4'h5, 1'b1);
        sample(32'h0fa0, 4'h5);
        sample(32'h1770, 4'h5);
        sample(32'h1b58, 4'h5);
        // result and status registers mirror the last transmitted sample
        rdchk(OFS_RESULT, 32'h0000_1b58);
        rdchk(OFS_STATUS, 32'h0000_000a);
        check({32'(expQ.size()), 4'h0}, 36'h0);
        end_of_test();
    end
endmodule : test_process_value_calc
